//--- hw/asm_pkg.sv
// Package of offsets, field positions and reset values for the amplifier status bank
package asm_pkg;
   // Register offsets
   localparam logic [7:0] ASM_OFS_CH0_FPM = 8'h60;
   localparam logic [7:0] ASM_OFS_CH0_HLT = 8'h61;
   localparam logic [7:0] ASM_OFS_CH0_MOD = 8'h62;
   localparam logic [7:0] ASM_OFS_CH1_FPM = 8'h64;
   localparam logic [7:0] ASM_OFS_CH1_HLT = 8'h65;
   localparam logic [7:0] ASM_OFS_CH1_MOD = 8'h66;
   localparam logic [7:0] ASM_OFS_STICKY = 8'h6D;
   localparam logic [7:0] ASM_OFS_OUTCFG = 8'h75;
   localparam logic [7:0] ASM_OFS_LIVE = 8'h7C;
   // Frequency/power mode register fields
   localparam int ASM_FREQ_LSB = 4;
   localparam int ASM_FREQ_MSB = 6;
   localparam int ASM_PWR_LSB = 0;
   localparam int ASM_PWR_MSB = 1;
   // Health flag register fields
   localparam int ASM_BIT_SILENCED = 5;
   localparam int ASM_BIT_LOGIC_OK = 4;
   localparam int ASM_BIT_POWER_OK = 3;
   localparam int ASM_BIT_FC2_OK = 2;
   localparam int ASM_BIT_FC1_OK = 1;
   localparam int ASM_BIT_OC_EVT = 0;
   // Output configuration field
   localparam int ASM_OUTCFG_MSB = 2;
   // Fault bit assignment, shared by live and sticky registers
   localparam int ASM_FLT_FLYCAP_OV = 0;
   localparam int ASM_FLT_OVERCURRENT = 1;
   localparam int ASM_FLT_PLL = 2;
   localparam int ASM_FLT_SUPPLY_UV = 3;
   localparam int ASM_FLT_OT_WARN = 4;
   localparam int ASM_FLT_OT_ERR = 5;
   localparam int ASM_FLT_PIN_SHORT = 6;
   localparam int ASM_FLT_DC_PROT = 7;
   localparam int ASM_FLT_W = 8;
   // Reset values
   localparam logic [7:0] ASM_RST_BYTE = 8'h00;
   localparam logic [7:0] ASM_RST_FAULT = 8'h00;
endpackage : asm_pkg

//--- hw/asm_chan_mon.sv
// One channel's monitor bytes: mode, health flags and modulation index
`timescale 1ns/100ps
module asm_chan_mon
   import asm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Channel status from the modulator and supervisors
   input wire logic [2:0] switch_freq_mode,
   input wire logic [1:0] power_mode_state,
   input wire logic silenced_flag,
   input wire logic logic_supply_good,
   input wire logic power_supply_good,
   input wire logic flycap2_good,
   input wire logic flycap1_good,
   input wire logic overcurrent_event,
   input wire logic [7:0] mod_index_value,
   // Register images
   output logic [7:0] fpm_r,
   output logic [7:0] health_r,
   output logic [7:0] mod_r
);
   logic [7:0] fpm_nxt;
   logic [7:0] health_nxt;

   always_comb begin
      fpm_nxt = 8'h00;
      fpm_nxt[ASM_FREQ_MSB:ASM_FREQ_LSB] = switch_freq_mode;
      fpm_nxt[ASM_PWR_MSB:ASM_PWR_LSB] = power_mode_state;
   end

   always_comb begin
      health_nxt = 8'h00;
      health_nxt[ASM_BIT_SILENCED] = silenced_flag;
      health_nxt[ASM_BIT_LOGIC_OK] = logic_supply_good;
      health_nxt[ASM_BIT_POWER_OK] = power_supply_good;
      health_nxt[ASM_BIT_FC2_OK] = flycap2_good;
      health_nxt[ASM_BIT_FC1_OK] = flycap1_good;
      health_nxt[ASM_BIT_OC_EVT] = overcurrent_event;
   end

   // Live sampling every cycle; no host write path exists
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fpm_r <= ASM_RST_BYTE;
         health_r <= ASM_RST_BYTE;
         mod_r <= ASM_RST_BYTE;
      end else begin
         fpm_r <= fpm_nxt;
         health_r <= health_nxt;
         mod_r <= mod_index_value;
      end
   end
endmodule : asm_chan_mon

//--- hw/asm_fault_acc.sv
// Live and sticky fault registers
`timescale 1ns/100ps
module asm_fault_acc
   import asm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Fault sources and clear strobe from the error-handler clear register
   input wire logic [ASM_FLT_W-1:0] fault_src,
   input wire logic fault_clear,
   // Register images
   output logic [ASM_FLT_W-1:0] live_r,
   output logic [ASM_FLT_W-1:0] sticky_r
);
   logic [ASM_FLT_W-1:0] sticky_nxt;

   // Set wins over clear so an event in the clear cycle is kept
   always_comb begin
      sticky_nxt = (sticky_r & ~{ASM_FLT_W{fault_clear}}) | fault_src;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         live_r <= ASM_RST_FAULT;
      end else begin
         live_r <= fault_src;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sticky_r <= ASM_RST_FAULT;
      end else begin
         sticky_r <= sticky_nxt;
      end
   end
endmodule : asm_fault_acc

//--- hw/asm_status_bank.sv
// Read-only status and monitor register bank of the two-channel amplifier
//
// Function
// - Channel 0 frequency mode at 0x60 bits 6:4
// - Channel 0 power mode at bits 1:0
// - Channel 0 health flags at 0x61 bits 5:0
// - Channel 0 modulation index byte at 0x62
// - Channel 1 copies at 0x64, 0x65, 0x66
// - Sticky fault bits latch until cleared
// - Fault bit order shared by both registers
// - Live fault register shows present state
// - Output configuration code at 0x75 bits 2:0
`timescale 1ns/100ps
module asm_status_bank
   import asm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Register port from the serial control interface
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd_en,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_r,
   output logic reg_rvalid_r,
   output logic reg_hit_r,
   output logic reg_wr_reject_r,
   // Channel 0 status
   input wire logic [2:0] ch0_switch_freq_mode,
   input wire logic [1:0] ch0_power_mode_state,
   input wire logic ch0_silenced_flag,
   input wire logic ch0_logic_supply_good,
   input wire logic ch0_power_supply_good,
   input wire logic ch0_flycap2_good,
   input wire logic ch0_flycap1_good,
   input wire logic ch0_overcurrent_event,
   input wire logic [7:0] ch0_mod_index_value,
   // Channel 1 status
   input wire logic [2:0] ch1_switch_freq_mode,
   input wire logic [1:0] ch1_power_mode_state,
   input wire logic ch1_silenced_flag,
   input wire logic ch1_logic_supply_good,
   input wire logic ch1_power_supply_good,
   input wire logic ch1_flycap2_good,
   input wire logic ch1_flycap1_good,
   input wire logic ch1_overcurrent_event,
   input wire logic [7:0] ch1_mod_index_value,
   // Output stage configuration pins
   input wire logic [2:0] out_cfg_sel,
   // Fault sources and clear strobe
   input wire logic [ASM_FLT_W-1:0] fault_src,
   input wire logic fault_clear
);
   ////////////////////////////////////////////////////////////////////////////////
   // Address decode
   function automatic logic asm_addr_mapped(input logic [7:0] a);
      case (a)
         ASM_OFS_CH0_FPM, ASM_OFS_CH0_HLT, ASM_OFS_CH0_MOD,
         ASM_OFS_CH1_FPM, ASM_OFS_CH1_HLT, ASM_OFS_CH1_MOD,
         ASM_OFS_STICKY, ASM_OFS_OUTCFG, ASM_OFS_LIVE: asm_addr_mapped = 1'b1;
         default: asm_addr_mapped = 1'b0;
      endcase
   endfunction : asm_addr_mapped

   ////////////////////////////////////////////////////////////////////////////////
   // Per-channel monitors
   logic [2:0] cf_freq [2];
   logic [1:0] cf_pwr [2];
   logic [5:0] cf_flags [2];
   logic [7:0] cf_mod [2];
   logic [7:0] ch_fpm [2];
   logic [7:0] ch_health [2];
   logic [7:0] ch_mod [2];

   assign cf_freq[0] = ch0_switch_freq_mode;
   assign cf_freq[1] = ch1_switch_freq_mode;
   assign cf_pwr[0] = ch0_power_mode_state;
   assign cf_pwr[1] = ch1_power_mode_state;
   assign cf_flags[0] = {ch0_silenced_flag, ch0_logic_supply_good, ch0_power_supply_good,
                         ch0_flycap2_good, ch0_flycap1_good, ch0_overcurrent_event};
   assign cf_flags[1] = {ch1_silenced_flag, ch1_logic_supply_good, ch1_power_supply_good,
                         ch1_flycap2_good, ch1_flycap1_good, ch1_overcurrent_event};
   assign cf_mod[0] = ch0_mod_index_value;
   assign cf_mod[1] = ch1_mod_index_value;

   // Both channels share one layout
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_chan
         asm_chan_mon u_chan (
            .clk(clk),
            .arst_n(arst_n),
            .switch_freq_mode(cf_freq[gi]),
            .power_mode_state(cf_pwr[gi]),
            .silenced_flag(cf_flags[gi][5]),
            .logic_supply_good(cf_flags[gi][4]),
            .power_supply_good(cf_flags[gi][3]),
            .flycap2_good(cf_flags[gi][2]),
            .flycap1_good(cf_flags[gi][1]),
            .overcurrent_event(cf_flags[gi][0]),
            .mod_index_value(cf_mod[gi]),
            .fpm_r(ch_fpm[gi]),
            .health_r(ch_health[gi]),
            .mod_r(ch_mod[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Faults and output configuration
   logic [ASM_FLT_W-1:0] live_q;
   logic [ASM_FLT_W-1:0] sticky_q;
   logic [7:0] outcfg_r;

   asm_fault_acc u_fault (
      .clk(clk),
      .arst_n(arst_n),
      .fault_src(fault_src),
      .fault_clear(fault_clear),
      .live_r(live_q),
      .sticky_r(sticky_q)
   );

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         outcfg_r <= ASM_RST_BYTE;
      end else begin
         outcfg_r <= {5'h00, out_cfg_sel};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read path
   logic [7:0] rd_mux;

   always_comb begin
      case (reg_addr)
         ASM_OFS_CH0_FPM: rd_mux = ch_fpm[0];
         ASM_OFS_CH0_HLT: rd_mux = ch_health[0];
         ASM_OFS_CH0_MOD: rd_mux = ch_mod[0];
         ASM_OFS_CH1_FPM: rd_mux = ch_fpm[1];
         ASM_OFS_CH1_HLT: rd_mux = ch_health[1];
         ASM_OFS_CH1_MOD: rd_mux = ch_mod[1];
         ASM_OFS_STICKY: rd_mux = sticky_q;
         ASM_OFS_OUTCFG: rd_mux = outcfg_r;
         ASM_OFS_LIVE: rd_mux = live_q;
         default: rd_mux = 8'h00;
      endcase
   end

   // Data holds until the next read so a slow serial shifter can take it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata_r <= ASM_RST_BYTE;
      end else if (reg_rd_en) begin
         reg_rdata_r <= rd_mux;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rvalid_r <= 1'b0;
         reg_hit_r <= 1'b0;
      end else begin
         reg_rvalid_r <= reg_rd_en;
         reg_hit_r <= (reg_rd_en | reg_wr_en) & asm_addr_mapped(reg_addr);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Write path: every offset here is read-only, data is dropped
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_wr_reject_r <= 1'b0;
      end else begin
         reg_wr_reject_r <= reg_wr_en & asm_addr_mapped(reg_addr);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   a_rd_ch0_freq: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd_en && reg_addr == ASM_OFS_CH0_FPM |=>
      reg_rdata_r[ASM_FREQ_MSB:ASM_FREQ_LSB] == $past(ch0_switch_freq_mode, 2)
      && reg_rdata_r[7] == 1'b0)
      else $error("channel 0 frequency mode read wrong");

   a_rd_ch0_power: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd_en && reg_addr == ASM_OFS_CH0_FPM |=>
      reg_rdata_r[ASM_PWR_MSB:ASM_PWR_LSB] == $past(ch0_power_mode_state, 2)
      && reg_rdata_r[3:2] == 2'h0)
      else $error("channel 0 power mode read wrong");

   a_rd_ch0_flags: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd_en && reg_addr == ASM_OFS_CH0_HLT |=>
      reg_rdata_r == {2'h0, $past(ch0_silenced_flag, 2), $past(ch0_logic_supply_good, 2),
      $past(ch0_power_supply_good, 2), $past(ch0_flycap2_good, 2),
      $past(ch0_flycap1_good, 2), $past(ch0_overcurrent_event, 2)})
      else $error("channel 0 health flags read wrong");

   a_rd_ch0_mod: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd_en && reg_addr == ASM_OFS_CH0_MOD |=>
      reg_rdata_r == $past(ch0_mod_index_value, 2))
      else $error("channel 0 modulation index read wrong");

   a_rd_ch1_mode: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd_en && reg_addr == ASM_OFS_CH1_FPM |=>
      reg_rdata_r == {1'b0, $past(ch1_switch_freq_mode, 2), 2'h0,
      $past(ch1_power_mode_state, 2)})
      else $error("channel 1 mode byte read wrong");

   a_rd_ch1_mirror: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd_en && reg_addr == ASM_OFS_CH1_HLT |=>
      reg_rdata_r == {2'h0, $past(ch1_silenced_flag, 2), $past(ch1_logic_supply_good, 2),
      $past(ch1_power_supply_good, 2), $past(ch1_flycap2_good, 2),
      $past(ch1_flycap1_good, 2), $past(ch1_overcurrent_event, 2)})
      else $error("channel 1 health flags read wrong");

   a_rd_ch1_mod: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd_en && reg_addr == ASM_OFS_CH1_MOD |=>
      reg_rdata_r == $past(ch1_mod_index_value, 2))
      else $error("channel 1 modulation index read wrong");

   a_sticky_sets: assert property (@(posedge clk) disable iff (!arst_n)
      fault_src != 8'h00 |=> (sticky_q & $past(fault_src)) == $past(fault_src))
      else $error("sticky fault bit failed to set");

   a_sticky_holds: assert property (@(posedge clk) disable iff (!arst_n)
      !fault_clear |=> (sticky_q & $past(sticky_q)) == $past(sticky_q))
      else $error("sticky fault bit dropped without clear");

   a_sticky_clears: assert property (@(posedge clk) disable iff (!arst_n)
      fault_clear && fault_src == 8'h00 |=> sticky_q == 8'h00)
      else $error("sticky fault register not cleared");

   // A sticky bit may only rise where its own source was seen
   a_sticky_cause: assert property (@(posedge clk) disable iff (!arst_n)
      1'b1 |=> (sticky_q & ~$past(sticky_q) & ~$past(fault_src)) == 8'h00)
      else $error("sticky fault bit set without a source");

   a_fault_order: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd_en && reg_addr == ASM_OFS_STICKY && !$past(fault_clear) |=>
      reg_rdata_r[ASM_FLT_PLL] >= $past(fault_src[ASM_FLT_PLL], 2)
      && reg_rdata_r[ASM_FLT_DC_PROT] >= $past(fault_src[ASM_FLT_DC_PROT], 2))
      else $error("sticky fault bit position wrong");

   a_live_follows: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd_en && reg_addr == ASM_OFS_LIVE |=> reg_rdata_r == $past(fault_src, 2))
      else $error("live fault register not current");

   a_live_no_latch: assert property (@(posedge clk) disable iff (!arst_n)
      1'b1 |=> live_q == $past(fault_src))
      else $error("live fault register kept a stale value");

   a_outcfg_code: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd_en && reg_addr == ASM_OFS_OUTCFG |=>
      reg_rdata_r == {5'h00, $past(out_cfg_sel, 2)})
      else $error("output configuration code read wrong");

   // Writes never touch contents; the reject pulse and the hit flag answer those to mapped offsets
   a_write_ignored: assert property (@(posedge clk) disable iff (!arst_n)
      reg_wr_en && asm_addr_mapped(reg_addr) && !reg_rd_en
      |=> reg_wr_reject_r && $stable(reg_rdata_r))
      else $error("write to read-only bank not rejected");

   a_wr_hit_flag: assert property (@(posedge clk) disable iff (!arst_n)
      reg_wr_en && asm_addr_mapped(reg_addr) |=> reg_hit_r)
      else $error("write to mapped offset gave no hit");

   a_reject_cause: assert property (@(posedge clk) disable iff (!arst_n)
      !(reg_wr_en && asm_addr_mapped(reg_addr)) |=> !reg_wr_reject_r)
      else $error("write reject without a mapped write");

   a_unmapped_wr: assert property (@(posedge clk) disable iff (!arst_n)
      reg_wr_en && !reg_rd_en && !asm_addr_mapped(reg_addr) |=> !reg_hit_r)
      else $error("unmapped write gave a hit");

   a_unmapped_zero: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd_en && !asm_addr_mapped(reg_addr) |=> reg_rdata_r == 8'h00 && !reg_hit_r)
      else $error("unmapped read not zero");

   // Answer strobes are pulses; the serial shifter counts on that
   a_rd_valid_pulse: assert property (@(posedge clk) disable iff (!arst_n)
      1'b1 |=> reg_rvalid_r == $past(reg_rd_en))
      else $error("read strobe not a one-cycle echo of the request");

   a_rdata_holds: assert property (@(posedge clk) disable iff (!arst_n)
      !reg_rd_en |=> $stable(reg_rdata_r))
      else $error("read data changed without a read");

   // Main scenarios
   c_read_live_fault: cover property (@(posedge clk) disable iff (!arst_n)
      reg_rd_en && reg_addr == ASM_OFS_LIVE ##1 reg_rdata_r != 8'h00);
   c_sticky_clear_race: cover property (@(posedge clk) disable iff (!arst_n)
      fault_clear && fault_src != 8'h00);
   c_read_sticky: cover property (@(posedge clk) disable iff (!arst_n)
      reg_rd_en && reg_addr == ASM_OFS_STICKY ##1 reg_rdata_r != 8'h00);
   c_write_reject: cover property (@(posedge clk) disable iff (!arst_n)
      reg_wr_en ##1 reg_wr_reject_r);
   c_read_ch1_mod: cover property (@(posedge clk) disable iff (!arst_n)
      reg_rd_en && reg_addr == ASM_OFS_CH1_MOD ##1 reg_rdata_r == 8'hFF);
endmodule : asm_status_bank

//--- test/asm_host_model.sv
// Host side model that drives the status bank's register port and the fault clear strobe
`timescale 1ns/100ps
module asm_host_model
   import asm_pkg::*;
(
   // Clock
   input wire logic clk,
   // Register port towards the bank
   output logic [7:0] reg_addr,
   output logic reg_rd_en,
   output logic reg_wr_en,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata_r,
   input wire logic reg_rvalid_r,
   input wire logic reg_hit_r,
   input wire logic reg_wr_reject_r,
   // Write strobe of the error-handler clear register
   output logic fault_clear
);
   initial begin
      reg_addr = 8'h00;
      reg_rd_en = 1'b0;
      reg_wr_en = 1'b0;
      reg_wdata = 8'h00;
      fault_clear = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One-cycle read request; the strobes stand only in the cycle after the taking edge, the data until the next read
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v,
                     output logic h);
      @(posedge clk);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      // Released address is inverted so a late sample cannot look correct
      reg_addr <= ~a;
      // Strobes are one-cycle pulses, so take them once this edge has settled
      #1;
      d = reg_rdata_r;
      v = reg_rvalid_r;
      h = reg_hit_r;
   endtask : rd
   ////////////////////////////////////////////////////////////////////////////////
   // One-cycle write request; the bank drops the data and raises the reject pulse at mapped offsets only
   task automatic wr(input logic [7:0] a, input logic [7:0] dt, output logic rj,
                     output logic h);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= dt;
      reg_wr_en <= 1'b1;
      @(posedge clk);
      reg_wr_en <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~dt;
      #1;
      rj = reg_wr_reject_r;
      h = reg_hit_r;
   endtask : wr
   ////////////////////////////////////////////////////////////////////////////////
   // Sticky faults are cleared only through the clear register or a reset, never by a bank write
   task automatic clear_faults();
      @(posedge clk);
      fault_clear <= 1'b1;
      @(posedge clk);
      fault_clear <= 1'b0;
   endtask : clear_faults
endmodule : asm_host_model

//--- test/tb_asm_status_bank.sv
// Self-checking testbench of the amplifier status register bank
`timescale 1ns/100ps
module tb_asm_status_bank
   import asm_pkg::*;
();
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_r;
   logic reg_rd_en, reg_wr_en, reg_rvalid_r, reg_hit_r, reg_wr_reject_r, fault_clear;
   logic [2:0] fm [2];
   logic [1:0] pm [2];
   logic [5:0] fl [2];
   logic [7:0] mi [2];
   logic [2:0] out_cfg_sel;
   logic [7:0] fault_src;
   int miscompares = 0;
   int check_count = 0;
   localparam logic [7:0] OFS [9] = '{ASM_OFS_CH0_FPM, ASM_OFS_CH0_HLT, ASM_OFS_CH0_MOD,
      ASM_OFS_CH1_FPM, ASM_OFS_CH1_HLT, ASM_OFS_CH1_MOD, ASM_OFS_STICKY, ASM_OFS_OUTCFG,
      ASM_OFS_LIVE};
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   asm_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en),
      .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
      .reg_rvalid_r(reg_rvalid_r), .reg_hit_r(reg_hit_r),
      .reg_wr_reject_r(reg_wr_reject_r), .fault_clear(fault_clear));
   asm_status_bank dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
      .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .reg_hit_r(reg_hit_r),
      .reg_wr_reject_r(reg_wr_reject_r),
      .ch0_switch_freq_mode(fm[0]), .ch0_power_mode_state(pm[0]),
      .ch0_silenced_flag(fl[0][5]), .ch0_logic_supply_good(fl[0][4]),
      .ch0_power_supply_good(fl[0][3]), .ch0_flycap2_good(fl[0][2]),
      .ch0_flycap1_good(fl[0][1]), .ch0_overcurrent_event(fl[0][0]),
      .ch0_mod_index_value(mi[0]),
      .ch1_switch_freq_mode(fm[1]), .ch1_power_mode_state(pm[1]),
      .ch1_silenced_flag(fl[1][5]), .ch1_logic_supply_good(fl[1][4]),
      .ch1_power_supply_good(fl[1][3]), .ch1_flycap2_good(fl[1][2]),
      .ch1_flycap1_good(fl[1][1]), .ch1_overcurrent_event(fl[1][0]),
      .ch1_mod_index_value(mi[1]),
      .out_cfg_sel(out_cfg_sel), .fault_src(fault_src), .fault_clear(fault_clear));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (miscompares == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   task automatic chk1(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask : chk1
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask : chk8
   // Read, then check data, the answer strobe and the map hit
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input logic hit);
      logic [7:0] d;
      logic v;
      logic h;
      host.rd(a, d, v, h);
      chk8(d, exp);
      chk1(v, 1'b1);
      chk1(h, hit);
   endtask : rdchk
   // Status inputs reach read data two edges later, so let them settle first
   task automatic settle();
      repeat (3) @(posedge clk);
   endtask : settle
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      end_of_test();
   end
   initial begin
      logic rj;
      logic h;
      for (int c = 0; c < 2; c++) begin
         fm[c] = 3'h0;
         pm[c] = 2'h0;
         fl[c] = 6'h00;
         mi[c] = 8'h00;
      end
      out_cfg_sel = 3'h0;
      fault_src = 8'h00;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      for (int k = 0; k < 9; k++) rdchk(OFS[k], ASM_RST_BYTE, 1'b1);
      // Opposite patterns per channel and per pass except channel 1 modulation index (0x80/0xFF), so every field bit but its bit 7 is seen both ways
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         fm[0] <= p ? 3'h2 : 3'h5;
         pm[0] <= p ? 2'h1 : 2'h2;
         fl[0] <= p ? 6'h15 : 6'h2A;
         mi[0] <= p ? 8'h00 : 8'hFF;
         fm[1] <= p ? 3'h5 : 3'h2;
         pm[1] <= p ? 2'h2 : 2'h1;
         fl[1] <= p ? 6'h2A : 6'h15;
         mi[1] <= p ? 8'hFF : 8'h80;
         settle();
         rdchk(ASM_OFS_CH0_FPM, {1'b0, fm[0], 2'b00, pm[0]}, 1'b1);
         rdchk(ASM_OFS_CH0_HLT, {2'b00, fl[0]}, 1'b1);
         rdchk(ASM_OFS_CH0_MOD, mi[0], 1'b1);
         rdchk(ASM_OFS_CH1_FPM, {1'b0, fm[1], 2'b00, pm[1]}, 1'b1);
         rdchk(ASM_OFS_CH1_HLT, {2'b00, fl[1]}, 1'b1);
         rdchk(ASM_OFS_CH1_MOD, mi[1], 1'b1);
      end
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         out_cfg_sel <= 3'(i);
         settle();
         rdchk(ASM_OFS_OUTCFG, 8'(i), 1'b1);
      end
      // One source at a time: live follows it, sticky keeps every past one
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         fault_src <= 8'h01 << i;
         settle();
         rdchk(ASM_OFS_LIVE, 8'h01 << i, 1'b1);
         rdchk(ASM_OFS_STICKY, 8'((16'h0002 << i) - 16'h0001), 1'b1);
         @(posedge clk);
         fault_src <= 8'h00;
         settle();
         rdchk(ASM_OFS_LIVE, 8'h00, 1'b1);
      end
      rdchk(ASM_OFS_STICKY, 8'hFF, 1'b1);
      // A source still active at the clear edge wins over the clear
      @(posedge clk);
      fault_src <= 8'h04;
      host.clear_faults();
      settle();
      rdchk(ASM_OFS_STICKY, 8'h04, 1'b1);
      @(posedge clk);
      fault_src <= 8'h81;
      settle();
      @(posedge clk);
      fault_src <= 8'h00;
      host.clear_faults();
      settle();
      rdchk(ASM_OFS_STICKY, 8'h00, 1'b1);
      @(posedge clk);
      fault_src <= 8'h81;
      @(posedge clk);
      fault_src <= 8'h00;
      settle();
      for (int k = 0; k < 9; k++) begin
         host.wr(OFS[k], 8'hFF, rj, h);
         chk1(rj, 1'b1);
         chk1(h, 1'b1);
      end
      host.wr(ASM_OFS_STICKY, 8'h00, rj, h);
      rdchk(ASM_OFS_STICKY, 8'h81, 1'b1);
      rdchk(ASM_OFS_LIVE, 8'h00, 1'b1);
      rdchk(ASM_OFS_OUTCFG, 8'h07, 1'b1);
      rdchk(ASM_OFS_CH1_MOD, 8'hFF, 1'b1);
      rdchk(8'h63, 8'h00, 1'b0);
      rdchk(8'h7F, 8'h00, 1'b0);
      host.wr(8'h63, 8'hA5, rj, h);
      chk1(rj, 1'b0);
      chk1(h, 1'b0);
      // Reset in mid-run drops the sticky history
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      settle();
      rdchk(ASM_OFS_STICKY, ASM_RST_FAULT, 1'b1);
      end_of_test();
   end
endmodule : tb_asm_status_bank
